// ### design/paired_single_fp_unit.sv
// Paired single-precision absolute, pack, min/max and compare datapath
//
// Contract
// - Absolute value clears both half signs
// - Paired results get integer exponent, positive
// - Any NaT source that is read gives NaT result; abs reads only the second
// - Pack converts both sources to singles
// - Max picks first only on larger magnitude
// - Min picks first only on smaller magnitude
// - NaN halves in max/min return second
// - Max/min invalid like less-than compare
// - Max/min raise only invalid and denormal exceptions
// - Compare both halves on selected relation
// - Four relations plus their complements
// - Quiet NaN invalid only for ordering relations
`timescale 1ns/1ns
`default_nettype none
module paired_single_fp_unit (
	input wire logic clk, // Core clock, 10 MHz
	input wire logic rst_b, // Asynchronous reset, active low
	input wire fp_pair_pkg::fp_request_type request, // Decoded operation
	output fp_pair_pkg::float_register_type result, // Destination value
	output logic result_valid, // One cycle after each request
	output logic write_enable, // Destination is to be written
	output fp_pair_pkg::fp_exception_type exceptions // Raised exceptions
);
	import fp_pair_pkg::*;

	// -----------------------------------------------------------------
	// Operand decode
	// -----------------------------------------------------------------
	logic nat_source; // A source is the NaT marker
	logic issue; // Request with true predicate
	logic [31:0] pack_hi; // Converted first source
	logic [31:0] pack_lo; // Converted second source
	logic [31:0] lane_hi; // High lane result
	logic [31:0] lane_lo; // Low lane result
	logic inv_hi, inv_lo; // Lane invalid flags
	logic den_hi, den_lo; // Lane denormal flags
	float_register_type next_result; // Value for the destination
	fp_exception_type next_exceptions; // Exceptions for this request

	// Either source holding the marker forces it out; abs reads only the second
	assign nat_source = (request.second == NATVAL) || (request.op != OP_ABS && request.first == NATVAL);
	assign issue = request.valid && request.qualifying_predicate;

	// -----------------------------------------------------------------
	// Pack converters
	// -----------------------------------------------------------------
	// first source converted
	pack_single u_pack_hi (
		.value(request.first),
		.single(pack_hi)
	);

	pack_single u_pack_lo (
		.value(request.second),
		.single(pack_lo)
	);

	// -----------------------------------------------------------------
	// Paired lanes
	// -----------------------------------------------------------------
	// high half evaluated alone
	pair_lane u_lane_hi (
		.op(request.op),
		.relation(request.relation),
		.first(request.first.significand[63:HI_LSB]),
		.second(request.second.significand[63:HI_LSB]),
		.result(lane_hi),
		.invalid(inv_hi),
		.denormal(den_hi)
	);

	pair_lane u_lane_lo (
		.op(request.op),
		.relation(request.relation),
		.first(request.first.significand[HI_LSB-1:0]),
		.second(request.second.significand[HI_LSB-1:0]),
		.result(lane_lo),
		.invalid(inv_lo),
		.denormal(den_lo)
	);

	// -----------------------------------------------------------------
	// Result assembly
	// -----------------------------------------------------------------
	// Chooses the destination value for a request
	always_comb begin
		next_result.sign = SIGN_POSITIVE;
		next_result.exponent = INTEGER_EXP;
		next_result.significand = {lane_hi, lane_lo};
		if (request.op == OP_PACK) begin
			next_result.significand = {pack_hi, pack_lo};
		end
		if (nat_source) begin
			next_result = NATVAL;
		end
	end

	// Exceptions for a request that computes
	always_comb begin
		next_exceptions = '0;
		if (request.op != OP_PACK && request.op != OP_ABS) begin
			next_exceptions.invalid = inv_hi || inv_lo;
			next_exceptions.denormal = den_hi || den_lo;
		end
		// Assist fault is never requested by this datapath
		next_exceptions.assist_fault = 1'b0;
	end

	// -----------------------------------------------------------------
	// Destination register
	// -----------------------------------------------------------------
	// Holds the last written value
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			result <= RESULT_RESET;
		end else if (issue) begin
			result <= next_result;
		end
	end

	// Completion strobes
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			result_valid <= 1'b0;
			write_enable <= 1'b0;
		end else begin
			result_valid <= request.valid;
			write_enable <= issue;
		end
	end

	// Exception report
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			exceptions <= '0;
		end else if (issue && !nat_source) begin
			exceptions <= next_exceptions;
		end else begin
			exceptions <= '0;
		end
	end

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	// Source classes recomputed apart from the lanes
	logic [127:0] src_halves; // First high, first low, second high, second low
	logic [3:0] nan_half; // Half holds a NaN
	logic [3:0] snan_half; // Half holds a signalling NaN

	assign src_halves = {request.first.significand, request.second.significand};

	// One class test per half
	for (genvar g = 0; g < 4; g++) begin : g_class
		assign nan_half[g] = (src_halves[32*g+30 -: 8] == SINGLE_SPECIAL_EXP) &&
			(src_halves[32*g+22 -: 23] != 23'h00_0000);
		assign snan_half[g] = nan_half[g] && !src_halves[32*g+SGL_QUIET];
	end

	a_abs_signs: assert property (@(posedge clk) disable iff (!rst_b)
		issue && !nat_source && request.op == OP_ABS |=>
		result.significand == {1'b0, $past(request.second.significand[62:32]),
		1'b0, $past(request.second.significand[30:0])})
		else $error("abs halves wrong");

	// exponent and sign of paired results
	a_integer_exp: assert property (@(posedge clk) disable iff (!rst_b)
		issue && !nat_source |=>
		write_enable && result.exponent == INTEGER_EXP && result.sign == SIGN_POSITIVE)
		else $error("paired exponent or sign wrong");

	a_natval_out: assert property (@(posedge clk) disable iff (!rst_b)
		issue && nat_source |=> result == NATVAL && exceptions == '0)
		else $error("NaT not propagated");

	// converted halves land in the significand
	a_pack_halves: assert property (@(posedge clk) disable iff (!rst_b)
		issue && !nat_source && request.op == OP_PACK |=>
		result.significand[63:32] == $past(pack_hi) && result.significand[31:0] == $past(pack_lo))
		else $error("pack order wrong");

	a_pack_quiet: assert property (@(posedge clk) disable iff (!rst_b)
		request.valid && request.op == OP_PACK |=> exceptions == '0)
		else $error("pack raised exception");

	// maximum picks first on strict magnitude lead
	a_amax_pick: assert property (@(posedge clk) disable iff (!rst_b)
		issue && !nat_source && request.op == OP_AMAX &&
		request.second.significand[62:32] < request.first.significand[62:32] &&
		!nan_half[3] && !nan_half[1] |=> result.significand[63:32] == $past(request.first.significand[63:32]))
		else $error("amax high half wrong");

	// minimum picks first on strict magnitude deficit
	a_amin_pick: assert property (@(posedge clk) disable iff (!rst_b)
		issue && !nat_source && request.op == OP_AMIN &&
		request.first.significand[30:0] < request.second.significand[30:0] &&
		!nan_half[2] && !nan_half[0] |=> result.significand[31:0] == $past(request.first.significand[31:0]))
		else $error("amin low half wrong");

	// NaN half answers with second source
	a_nan_second: assert property (@(posedge clk) disable iff (!rst_b)
		issue && !nat_source && (request.op == OP_AMAX || request.op == OP_AMIN) &&
		(nan_half[2] || nan_half[0]) |=> result.significand[31:0] == $past(request.second.significand[31:0]) &&
		exceptions.invalid)
		else $error("NaN half not second source");

	// max and min signal like less-than
	a_minmax_invalid: assert property (@(posedge clk) disable iff (!rst_b)
		issue && !nat_source && (request.op == OP_AMAX || request.op == OP_AMIN) |=>
		exceptions.invalid == $past(|nan_half) && !exceptions.assist_fault)
		else $error("minmax invalid mismatch");

	a_cmp_masks: assert property (@(posedge clk) disable iff (!rst_b)
		issue && !nat_source && request.op == OP_CMP |=>
		(result.significand[63:32] == 32'hFFFF_FFFF || result.significand[63:32] == 32'h0000_0000) &&
		(result.significand[31:0] == 32'hFFFF_FFFF || result.significand[31:0] == 32'h0000_0000))
		else $error("compare mask not uniform");

	a_cmp_complement: assert property (@(posedge clk) disable iff (!rst_b)
		issue && !nat_source && request.op == OP_CMP && request.relation == REL_UNORD
		##1 request.valid && request.qualifying_predicate && request.op == OP_CMP &&
		request.relation == REL_ORD && $stable(request.first) && $stable(request.second) |=>
		result.significand == ~$past(result.significand))
		else $error("complement relation not inverted");

	// quiet compare relations ignore quiet NaN
	a_quiet_relation: assert property (@(posedge clk) disable iff (!rst_b)
		issue && !nat_source && request.op == OP_CMP && request.relation[1:0] != 2'h1 &&
		request.relation[1:0] != 2'h2 |=> exceptions.invalid == $past(|snan_half))
		else $error("quiet relation invalid mismatch");

	a_pred_hold: assert property (@(posedge clk) disable iff (!rst_b)
		request.valid && !request.qualifying_predicate |=>
		result_valid && !write_enable && $stable(result) && exceptions == '0)
		else $error("false predicate changed state");

	// -----------------------------------------------------------------
	// Strobe, pack, max and exception checks
	// -----------------------------------------------------------------
	// strobes follow the request
	a_strobes: assert property (@(posedge clk) disable iff (!rst_b)
		1'b1 |=> result_valid == $past(request.valid) &&
		write_enable == $past(request.valid && request.qualifying_predicate))
		else $error("completion strobes wrong");

	a_idle_quiet: assert property (@(posedge clk) disable iff (!rst_b)
		!issue |=> $stable(result) && exceptions == '0)
		else $error("idle cycle changed state");

	a_order_invalid: assert property (@(posedge clk) disable iff (!rst_b)
		issue && !nat_source && request.op == OP_CMP &&
		(request.relation[1:0] == 2'h1 || request.relation[1:0] == 2'h2) |=>
		exceptions.invalid == $past(|nan_half))
		else $error("ordering relation invalid mismatch");

	a_pack_signs: assert property (@(posedge clk) disable iff (!rst_b)
		issue && !nat_source && request.op == OP_PACK |=>
		result.significand[63] == $past(request.first.sign) &&
		result.significand[31] == $past(request.second.sign))
		else $error("pack sign lost");

	a_pack_special: assert property (@(posedge clk) disable iff (!rst_b)
		issue && !nat_source && request.op == OP_PACK && request.first.exponent == SPECIAL_EXP |=>
		result.significand[62:55] == SINGLE_SPECIAL_EXP)
		else $error("pack special exponent wrong");

	a_amax_other: assert property (@(posedge clk) disable iff (!rst_b)
		issue && !nat_source && request.op == OP_AMAX &&
		!(request.second.significand[62:32] < request.first.significand[62:32]) |=>
		result.significand[63:32] == $past(request.second.significand[63:32]))
		else $error("amax second half not kept");

	a_abs_silent: assert property (@(posedge clk) disable iff (!rst_b)
		request.valid && request.op == OP_ABS |=> exceptions == '0)
		else $error("abs raised exception");

endmodule
`default_nettype wire

// ### inc/fp_pair_pkg.sv
// Shared types and constants for the paired single-precision datapath
package fp_pair_pkg;

	// -----------------------------------------------------------------
	// Register format layout
	// -----------------------------------------------------------------
	// One floating-point register: sign, 17-bit exponent, 64-bit significand
	typedef struct packed {
		logic sign; // Sign bit
		logic [16:0] exponent; // Biased exponent
		logic [63:0] significand; // Explicit-integer significand
	} float_register_type;

	// Biased exponent of two to the 63rd, used for all paired results
	localparam logic [16:0] INTEGER_EXP = 17'h1_003E;
	// Exponent marking infinities and NaNs in register format
	localparam logic [16:0] SPECIAL_EXP = 17'h1_FFFF;
	// Register bias minus single bias (0xFFFF - 0x7F)
	localparam logic [16:0] BIAS_SHIFT = 17'h0_FF80;
	// Single-precision all-ones exponent
	localparam logic [7:0] SINGLE_SPECIAL_EXP = 8'hFF;
	// Positive sign value
	localparam logic SIGN_POSITIVE = 1'b0;
	// Not-a-thing marker value
	localparam float_register_type NATVAL = '{sign: 1'b0, exponent: 17'h1_FFFE,
		significand: 64'h0000_0000_0000_0000};
	// Value of the result register after reset
	localparam float_register_type RESULT_RESET = '{sign: 1'b0, exponent: 17'h0_0000,
		significand: 64'h0000_0000_0000_0000};

	// -----------------------------------------------------------------
	// Field positions inside a single and inside the significand
	// -----------------------------------------------------------------
	localparam int HI_LSB = 32; // Low bit of the high half
	localparam int SGL_SIGN = 31; // Sign bit of a single
	localparam int SGL_QUIET = 22; // Quiet bit of a single NaN
	localparam int REG_FRAC_MSB = 62; // Top fraction bit of a register
	localparam int REG_FRAC_LSB = 40; // Lowest fraction bit kept by a single

	// -----------------------------------------------------------------
	// Operations and relations
	// -----------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_ABS = 3'h0, // Paired absolute value
		OP_PACK = 3'h1, // Pack two registers into singles
		OP_AMAX = 3'h2, // Paired absolute maximum
		OP_AMIN = 3'h3, // Paired absolute minimum
		OP_CMP = 3'h4 // Paired compare
	} op_type;

	// Bit 2 complements the base relation in bits 1:0
	typedef enum logic [2:0] {
		REL_EQ = 3'h0,
		REL_LT = 3'h1,
		REL_LE = 3'h2,
		REL_UNORD = 3'h3,
		REL_NEQ = 3'h4,
		REL_NLT = 3'h5,
		REL_NLE = 3'h6,
		REL_ORD = 3'h7
	} relation_type;

	// -----------------------------------------------------------------
	// Request and exception carriers
	// -----------------------------------------------------------------
	typedef struct packed {
		logic valid; // Operation issued this cycle
		op_type op; // Operation
		relation_type relation; // Compare relation
		logic qualifying_predicate; // Instruction predicate
		float_register_type first; // First source register
		float_register_type second; // Second source register
	} fp_request_type;

	typedef struct packed {
		logic invalid; // Invalid operation
		logic denormal; // Denormal or unnormal operand
		logic assist_fault; // Software-assist fault
	} fp_exception_type;

endpackage

// ### design/pack_single.sv
// Register-format to single-precision memory-format converter
`timescale 1ns/1ns
`default_nettype none
module pack_single (
	input wire fp_pair_pkg::float_register_type value, // Register-format source
	output logic [31:0] single // Single memory format
);
	import fp_pair_pkg::*;

	logic [7:0] exp_field; // Converted exponent
	logic [16:0] rebased; // Exponent moved to single bias

	// -----------------------------------------------------------------
	// Bit mapping without rounding, so nothing is ever signalled
	// -----------------------------------------------------------------
	assign rebased = value.exponent - BIAS_SHIFT;

	// Exponent selection by class
	always_comb begin
		if (value.exponent == SPECIAL_EXP) begin
			// Infinity or NaN
			exp_field = SINGLE_SPECIAL_EXP;
		end else if (!value.significand[63]) begin
			// Zero or denormal has no integer bit
			exp_field = 8'h00;
		end else begin
			exp_field = rebased[7:0];
		end
	end

	assign single = {value.sign, exp_field, value.significand[REG_FRAC_MSB:REG_FRAC_LSB]};
endmodule
`default_nettype wire

// ### design/pair_lane.sv
// One 32-bit half of the paired datapath
`timescale 1ns/1ns
`default_nettype none
module pair_lane (
	input wire fp_pair_pkg::op_type op, // Operation
	input wire fp_pair_pkg::relation_type relation, // Compare relation
	input wire logic [31:0] first, // First source half
	input wire logic [31:0] second, // Second source half
	output logic [31:0] result, // Result half
	output logic invalid, // Invalid operation
	output logic denormal // Denormal operand
);
	import fp_pair_pkg::*;

	logic nan_a, nan_b, snan, unord; // NaN classes
	logic zero_both, den_any; // Zero and denormal classes
	logic mag_a_lt, mag_b_lt; // Magnitude order
	logic less, equal, base, holds; // Relations
	logic ordering; // Relation orders its operands

	// -----------------------------------------------------------------
	// Operand classes
	// -----------------------------------------------------------------
	assign nan_a = (first[30:23] == SINGLE_SPECIAL_EXP) && (first[22:0] != 23'h00_0000);
	assign nan_b = (second[30:23] == SINGLE_SPECIAL_EXP) && (second[22:0] != 23'h00_0000);
	assign snan = (nan_a && !first[SGL_QUIET]) || (nan_b && !second[SGL_QUIET]);
	assign unord = nan_a || nan_b;
	assign zero_both = (first[30:0] == 31'h0000_0000) && (second[30:0] == 31'h0000_0000);
	assign den_any = ((first[30:23] == 8'h00) && (first[22:0] != 23'h00_0000))
		|| ((second[30:23] == 8'h00) && (second[22:0] != 23'h00_0000));
	assign mag_a_lt = first[30:0] < second[30:0];
	assign mag_b_lt = second[30:0] < first[30:0];

	// Signed less and equal, false when unordered
	always_comb begin
		if (unord || zero_both) begin
			less = 1'b0;
		end else if (first[SGL_SIGN] != second[SGL_SIGN]) begin
			less = first[SGL_SIGN];
		end else begin
			less = first[SGL_SIGN] ? mag_b_lt : mag_a_lt;
		end
	end
	assign equal = !unord && ((first == second) || zero_both);

	// four relations, complemented
	// Base relation; bit 2 complements it
	always_comb begin
		case (relation[1:0])
			2'h0: base = equal;
			2'h1: base = less;
			2'h2: base = less || equal;
			2'h3: base = unord;
			default: base = 1'b0;
		endcase
	end
	assign holds = base ^ relation[2];
	assign ordering = (relation[1:0] == 2'h1) || (relation[1:0] == 2'h2);

	// -----------------------------------------------------------------
	// Result and exception selection
	// -----------------------------------------------------------------
	always_comb begin
		result = second;
		invalid = 1'b0;
		denormal = 1'b0;
		case (op)
			OP_ABS: result = {SIGN_POSITIVE, second[30:0]};
			OP_AMAX: begin
				result = (!unord && mag_b_lt) ? first : second;
				invalid = unord;
				denormal = den_any && !unord;
			end
			OP_AMIN: begin
				result = (!unord && mag_a_lt) ? first : second;
				invalid = unord;
				denormal = den_any && !unord;
			end
			OP_CMP: begin
				result = holds ? 32'hFFFF_FFFF : 32'h0000_0000;
				invalid = snan || (ordering && unord);
				denormal = den_any && !unord;
			end
			default: result = second;
		endcase
	end
endmodule
`default_nettype wire

// ### testbench/fp_request_source.sv
// Model of the decoder and register file that issues paired operations
`timescale 1ns/1ns
`default_nettype none
module fp_request_source (
	input wire logic clk, // Core clock
	output fp_pair_pkg::fp_request_type request // Decoded operation
);
	import fp_pair_pkg::*;

	// Edge counter, kept so the model follows the core clock
	int edges = 0;

	// -----------------------------------------------------------------
	// Issue tasks, called just after a falling edge
	// -----------------------------------------------------------------

	// Nothing issued at time zero
	initial begin
		request = '0;
	end

	// Count rising edges seen
	always @(posedge clk) begin
		edges <= edges + 1;
	end

	// Present one operation until the next falling edge
	task automatic drive(input op_type op, input relation_type rel, input logic pred,
		input float_register_type a, input float_register_type b);
		request = '{valid: 1'b1, op: op, relation: rel, qualifying_predicate: pred, first: a, second: b};
	endtask

	task automatic drive_greater(input relation_type rel, input logic pred,
		input float_register_type a, input float_register_type b);
		drive(OP_CMP, rel, pred, b, a);
	endtask

	// Drop valid; stale fields are inverted so they are never reused
	task automatic release_bus();
		request = {1'b0, ~request[$bits(fp_request_type)-2:0]};
	endtask

endmodule
`default_nettype wire

// ### testbench/paired_single_fp_unit_tb.sv
// Self-checking testbench for the paired single-precision datapath
`timescale 1ns/1ns
`default_nettype none
module paired_single_fp_unit_tb;
	import fp_pair_pkg::*;

	// -----------------------------------------------------------------
	// Clock, reset and wiring
	// -----------------------------------------------------------------
	logic clk = 1'b0; // Core clock
	logic rst_b = 1'b0; // Reset, active low
	fp_request_type request; // From the issue model
	float_register_type result; // Destination value
	logic result_valid; // Answer strobe
	logic write_enable; // Destination write
	fp_exception_type exceptions; // Raised exceptions
	int n_errors = 0; // Mismatches
	int n_compared = 0; // Comparisons
	int cycles = 0; // Run length
	localparam int CYCLE_LIMIT = 2000; // Far above the planned run

	// 100 ns period
	always #50 clk = ~clk;

	fp_request_source i_src (.clk(clk), .request(request));

	paired_single_fp_unit i_dut (.clk(clk), .rst_b(rst_b), .request(request), .result(result),
		.result_valid(result_valid), .write_enable(write_enable), .exceptions(exceptions));

	// Hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == CYCLE_LIMIT) begin
			n_errors = n_errors + 1;
			summarize();
		end
	end

	// -----------------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------------

	// Paired result form: integer exponent, positive
	function automatic float_register_type paired(input logic [63:0] sig);
		return '{sign: SIGN_POSITIVE, exponent: INTEGER_EXP, significand: sig};
	endfunction

	// Compare and count
	task automatic check(input string what, input logic [81:0] seen, input logic [81:0] expected);
		n_compared++;
		if (seen !== expected) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, expected, seen);
		end
	endtask

	// Judge one answer cycle
	task automatic expect_out(input float_register_type res, input logic we, input logic [2:0] exc);
		check("result_valid", 82'(result_valid), 82'(1'b1));
		check("write_enable", 82'(write_enable), 82'(we));
		check("result", result, res);
		check("exceptions", 82'(exceptions), 82'(exc));
	endtask

	// One isolated operation and its answer
	task automatic run(input op_type op, input relation_type rel, input logic pred, input float_register_type a,
		input float_register_type b, input float_register_type res, input logic we, input logic [2:0] exc);
		@(negedge clk);
		i_src.drive(op, rel, pred, a, b);
		@(negedge clk);
		i_src.release_bus();
		expect_out(res, we, exc);
	endtask

	// -----------------------------------------------------------------
	// Scenarios
	// -----------------------------------------------------------------

	// Idle outputs after reset
	task automatic test_reset();
		@(negedge clk);
		check("reset result", result, RESULT_RESET);
		check("reset valid", 82'({result_valid, write_enable, exceptions}), 82'(0));
	endtask

	// Sign clearing on both halves, first source ignored
	task automatic test_abs();
		run(OP_ABS, REL_EQ, 1'b1, '{1'b1, 17'h0_1234, 64'hFFFF_FFFF_FFFF_FFFF}, '{1'b1, 17'h0_0005,
			64'hC040_0000_FFC0_0000}, paired(64'h4040_0000_7FC0_0000), 1'b1, 3'b000);
	endtask

	// Register to single conversion, upper half from first source
	task automatic test_pack();
		run(OP_PACK, REL_EQ, 1'b1, '{1'b0, 17'h0_FFFF, 64'h8000_0000_0000_0000}, '{1'b1, 17'h1_0000,
			64'h8000_0000_0000_0000}, paired(64'h3F80_0000_C000_0000), 1'b1, 3'b000);
		run(OP_PACK, REL_EQ, 1'b1, '{1'b0, 17'h1_FFFF, 64'h8000_0000_0000_0000}, '{1'b0, 17'h0_FFFF,
			64'hC000_0000_0000_0000}, paired(64'h7F80_0000_3FC0_0000), 1'b1, 3'b000);
	endtask

	// Magnitude selection, ties, NaN halves and denormal flag
	task automatic test_minmax();
		float_register_type a;
		float_register_type b;
		float_register_type n;
		a = paired(64'hC040_0000_3F80_0000);
		b = paired(64'h4000_0000_BF80_0000);
		n = paired(64'h7FC0_0000_3F80_0000);
		run(OP_AMAX, REL_EQ, 1'b1, a, b, paired(64'hC040_0000_BF80_0000), 1'b1, 3'b000);
		run(OP_AMIN, REL_EQ, 1'b1, a, b, paired(64'h4000_0000_BF80_0000), 1'b1, 3'b000);
		run(OP_AMAX, REL_EQ, 1'b1, n, paired(64'h3F80_0000_4000_0000), paired(64'h3F80_0000_4000_0000),
			1'b1, 3'b100);
		run(OP_AMIN, REL_EQ, 1'b1, n, paired(64'h3F80_0000_4000_0000), paired(64'h3F80_0000_3F80_0000),
			1'b1, 3'b100);
		run(OP_AMIN, REL_EQ, 1'b1, paired(64'h0000_0001_3F80_0000), paired(64'h3F80_0000_3F80_0000),
			paired(64'h0000_0001_3F80_0000), 1'b1, 3'b010);
	endtask

	// All eight relations, ordered high half and unordered low half
	task automatic test_compare();
		relation_type rel;
		logic [3:0] hi_base;
		logic [3:0] lo_base;
		logic hi;
		logic lo;
		hi_base = 4'b0110;
		lo_base = 4'b1000;
		for (int i = 0; i < 8; i++) begin
			rel = relation_type'(i);
			hi = hi_base[rel[1:0]] ^ rel[2];
			lo = lo_base[rel[1:0]] ^ rel[2];
			run(OP_CMP, rel, 1'b1, paired(64'h3F80_0000_7FC0_0000), paired(64'h4000_0000_3F80_0000),
				paired({{32{hi}}, {32{lo}}}), 1'b1, {rel[1:0] == 2'h1 || rel[1:0] == 2'h2, 2'b00});
		end
		@(negedge clk);
		i_src.drive_greater(REL_LT, 1'b1, paired(64'h4000_0000_3F80_0000), paired(64'h3F80_0000_3F80_0000));
		@(negedge clk);
		i_src.release_bus();
		expect_out(paired(64'hFFFF_FFFF_0000_0000), 1'b1, 3'b000);
		run(OP_CMP, REL_EQ, 1'b1, paired(64'h7FA0_0000_3F80_0000), paired(64'h3F80_0000_3F80_0000),
			paired(64'h0000_0000_FFFF_FFFF), 1'b1, 3'b100);
		@(negedge clk);
		i_src.drive(OP_CMP, REL_UNORD, 1'b1, paired(64'h3F80_0000_7FC0_0000), paired(64'h4000_0000_3F80_0000));
		@(negedge clk);
		expect_out(paired(64'h0000_0000_FFFF_FFFF), 1'b1, 3'b000);
		i_src.drive(OP_CMP, REL_ORD, 1'b1, paired(64'h3F80_0000_7FC0_0000), paired(64'h4000_0000_3F80_0000));
		@(negedge clk);
		i_src.release_bus();
		expect_out(paired(64'hFFFF_FFFF_0000_0000), 1'b1, 3'b000);
	endtask

	// Marker source replaces the pack and compare results
	task automatic test_nat();
		run(OP_PACK, REL_EQ, 1'b1, NATVAL, paired(64'h3F80_0000_3F80_0000), NATVAL, 1'b1, 3'b000);
		run(OP_CMP, REL_LT, 1'b1, paired(64'h7FC0_0000_7FC0_0000), NATVAL, NATVAL, 1'b1, 3'b000);
	endtask

	// Back to back: executed op, then a false-predicate op
	task automatic test_predicate();
		@(negedge clk);
		i_src.drive(OP_ABS, REL_EQ, 1'b1, NATVAL, paired(64'hBF80_0000_C000_0000));
		@(negedge clk);
		expect_out(paired(64'h3F80_0000_4000_0000), 1'b1, 3'b000);
		i_src.drive(OP_CMP, REL_LT, 1'b0, paired(64'h7FA0_0000_7FC0_0000), paired(64'h7FA0_0000_0000_0000));
		@(negedge clk);
		i_src.release_bus();
		expect_out(paired(64'h3F80_0000_4000_0000), 1'b0, 3'b000);
	endtask

	// -----------------------------------------------------------------
	// Verdict and main sequence
	// -----------------------------------------------------------------
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20) @(negedge clk);
		rst_b = 1'b1;
		test_reset();
		test_abs();
		test_pack();
		test_minmax();
		test_compare();
		test_nat();
		test_predicate();
		summarize();
	end

endmodule
`default_nettype wire
